/* File: bench/macro_instr_transform_decode_tb.sv */
// self-checking bench for the macro instruction transform decoder
`timescale 1ns/1ps
`default_nettype none
module macro_instr_transform_decode_tb
   import macro_xform_pkg::*;
;
   logic clk_sys_in = 1'b0;
   logic arst_n_in = 1'b0;
   wb_req_t wb_req_in = '0;
   wb_rsp_t wb_rsp_out;
   xform_out_t xform_out;
   logic [15:0] strobe_count;
   logic [31:0] last_word;
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int cmds = 0;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [31:0] msk_v;
   logic [31:0] exp_v;
   logic [31:0] seed = 32'h76D3;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end

   always #10 clk_sys_in = ~clk_sys_in;

   macro_instr_transform_decode macro_instr_transform_decode_inst (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .wb_req_in(wb_req_in),
      .wb_rsp_out(wb_rsp_out), .xform_out(xform_out));
   micro_seq_model micro_seq_model_inst (
      .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .xf_in(xform_out),
      .strobe_count_out(strobe_count), .last_word_out(last_word));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // expected transform index and upper micro command
   function automatic logic [19:0] exp_xf(input logic [15:0] h);
      logic [3:0] o;
      logic [3:0] m;
      logic z;
      logic [3:0] j;
      logic [15:0] c;
      o = h[15:12];
      m = h[11:8];
      z = (h[7:0] == 8'h00);
      j = J_PRI;
      c = MC_PINC_P_AB;
      if (o != OPC_REGREF) begin
         if (m[3:2] == 2'b01 || (m >= 4'hC && !z) || (z && m >= 4'h1 && m <= 4'h3)) j = J_ALT;
         else if (z && m >= 4'hC) j = J_MM;
         else if (!z && m == 4'h3) j = J_MM;
         else if (!z && (m <= 4'h2 || m == 4'h8)) j = J_OPC;
         if (!z) begin
            case (m)
               4'h0, 4'h4, 4'h5, 4'h6, 4'h7: c = MC_D_X_AB;
               4'h1, 4'h3: c = MC_DFF_X_AB;
               4'h2: c = MC_DQ_X_AB;
               default: c = MC_PDSE_X_AB;
            endcase
         end
      end else begin
         case (m)
            4'h0, 4'h4, 4'h5, 4'hB: c = MC_NOP;
            4'h1: j = J_SKIP;
            4'h2, 4'h3: c = MC_PDSE_F_AB;
            4'h6, 4'h7: c = MC_Q_X_AB;
            4'h8: begin
               j = h[3] ? J_IR : J_IM;
               c = MC_INTERREG;
            end
            4'hE: c = MC_DINT_X_AB;
            4'hF: begin
               j = J_SHIFT;
               c = MC_A_F;
            end
            default: ;
         endcase
      end
      return {j, c};
   endfunction

   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      wb_req_in <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (wb_rsp_out.ack !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         print_verdict();
      end
      wb_req_in <= '0;
      @(posedge clk_sys_in);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
      exp_q.push_back(e & msk);
      msk_q.push_back(msk);
      wb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic fetch(input logic [15:0] h, input logic [15:0] ml, input logic [1:0] cnd);
      logic [19:0] x;
      logic b;
      logic en;
      x = exp_xf(h);
      b = (h[11:10] == 2'b00) | cnd[0];
      en = (h[15:12] == OPC_REGREF) && (h[7:0] != 8'h00) &&
           (h[11:8] inside {4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB});
      wb(1'b1, REG_COND, {30'h0, cnd});
      wb(1'b1, REG_MACRO_DATA, {16'h0000, h});
      wb(1'b1, REG_MICRO_LOW, {16'h0000, ml});
      wb(1'b1, REG_CMD, 32'h0000_0001);
      cmds++;
      rd(REG_HOLD, 32'hFFFF_FFFF, {8'h00, h[7:0], h});
      rd(REG_MICRO_WORD, 32'hFFFF_FFFF, {x[15:0], ml});
      rd(REG_STATUS, 32'h0001_FF00,
         {15'h0, en, (h[7:0] == 8'h00) | b, cnd[1], b, h == IIN_CODE, x[19:16], 8'h00});
      `CHK(last_word, {x[15:0], ml})
   endtask

   // read results arrive with ack; the oldest note is compared
   always @(posedge clk_sys_in) begin
      if (arst_n_in && wb_rsp_out.ack === 1'b1 && wb_req_in.we === 1'b0 && exp_q.size() > 0) begin
         msk_v = msk_q.pop_front();
         exp_v = exp_q.pop_front();
         `CHK(wb_rsp_out.dat & msk_v, exp_v)
      end
   end

   task automatic print_verdict();
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk_sys_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   initial begin
      logic [15:0] h;
      repeat (3) @(posedge clk_sys_in);
      arst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      rd(REG_STATUS, 32'hFFFF_FFFF, 32'h0);
      rd(REG_HOLD, 32'hFFFF_FFFF, 32'h0);
      wb(1'b1, REG_HOLD, 32'h1234_5678);
      rd(REG_HOLD, 32'hFFFF_FFFF, 32'h0);
      rd(8'h40, 32'hFFFF_FFFF, 32'h0);
      rd(REG_CMD, 32'hFFFF_FFFF, 32'h0);
      $display("test reset_and_map done");
      for (int o = 0; o < 2; o++) begin
         for (int m = 0; m < 16; m++) begin
            fetch({o ? 4'hC : 4'h0, m[3:0], 8'h00}, 16'h5A5A, o[1:0]);
            fetch({o ? 4'hC : 4'h0, m[3:0], 8'h80}, 16'hC3C3, 2'b10);
         end
      end
      $display("test directed_fetch done");
      for (int i = 0; i < 40; i++) begin
         seed = lfsr_next(seed);
         h = seed[15:0];
         fetch(h, seed[31:16], seed[17:16]);
      end
      $display("test random_fetch done");
      wb(1'b1, REG_SELECTOR, 32'h0000_A5C3);
      for (int j = 0; j < 16; j++) begin
         wb(1'b1, REG_MICRO_LOW, {16'h0000, 12'hBE0, j[3:0]});
         wb(1'b1, REG_CMD, 32'h0000_0002);
         cmds++;
         rd(REG_STATUS, 32'h0000_1F00, {19'h0, 1'b1, j[3:0], 8'h00});
         rd(REG_MICRO_WORD, 32'h0000_FFFF, {16'h0000, 12'hBE0, j[3:0]});
         if (j == 7) rd(REG_STATUS, 32'h0000_00FF, 32'h0000_00C3);
         if (j == 7) `CHK(xform_out.addr, 8'hC3)
      end
      $display("test micro_index done");
      wb(1'b1, REG_SELECTOR, 32'h0000_0000);
      fetch(16'h0808, 16'h0001, 2'b00);
      fetch(16'h4123, 16'h0001, 2'b00);
      wb(1'b1, REG_MACRO_DATA, {16'h0000, IIN_CODE});
      wb(1'b1, REG_CMD, 32'h0000_0001);
      cmds++;
      rd(REG_STATUS, 32'h0000_1000, 32'h0000_1000);
      `CHK(strobe_count, cmds[15:0])
      $display("test cond_a done");
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: bench/micro_seq_model.sv */
// far-side model: micro instruction register capturing transform words and counting strobes
`timescale 1ns/1ps
`default_nettype none
module micro_seq_model
   import macro_xform_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire xform_out_t xf_in,
   output logic [15:0] strobe_count_out,
   output logic [31:0] last_word_out
);
   // takes the word and counts each strobe, as the instruction register would; the address is not kept
   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         strobe_count_out <= 16'h0000;
         last_word_out <= 32'h0000_0000;
      end else if (xf_in.strobe) begin
         strobe_count_out <= strobe_count_out + 16'h0001;
         last_word_out <= xf_in.word;
      end
   end
endmodule
`default_nettype wire

/* File: core/macro_instr_transform_decode.sv */
// macro instruction transform decoder with classic wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module macro_instr_transform_decode
   import macro_xform_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic arst_n_in,
   input wire wb_req_t wb_req_in,
   output wb_rsp_t wb_rsp_out,
   output xform_out_t xform_out
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [15:0] macro_data;
      logic [15:0] micro_low;
      logic [15:0] selector;
      logic [1:0] cond;
      logic [15:0] holder;
      logic [7:0] delta;
      logic [3:0] index;
      logic [7:0] addr;
      logic [31:0] micro_word;
      logic cond_a;
      logic cond_b;
      logic cond_c;
      logic cond_d;
      logic enhanced;
      logic strobe;
   } state_t;

   state_t s;
   state_t next_s;
   logic req_hit;
   logic wr_go;
   logic fetch_go;
   logic micro_go;
   logic [15:0] use_holder;
   logic [7:0] use_delta;
   logic [3:0] use_index;
   logic use_a;
   logic use_b;
   logic use_c;
   logic use_d;

   function automatic logic [3:0] opc_of(input logic [15:0] h);
      return h[OPC_HI:OPC_LO];
   endfunction

   function automatic logic [3:0] mode_of(input logic [15:0] h);
      return h[MODE_HI:MODE_LO];
   endfunction

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
      return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic reg_is(input logic [7:0] adr, input logic [7:0] off);
      return {adr[7:2], WORD_ALIGN} == off;
   endfunction

   // transform index picked from the held instruction
   function automatic logic [3:0] pick_index(input logic [15:0] h, input logic [7:0] dl);
      logic [3:0] m;
      logic dz;
      m = mode_of(h);
      dz = (dl == DELTA_ZERO);
      if (opc_of(h) == OPC_REGREF) begin
         unique case (m)
            4'h1: pick_index = J_SKIP;
            4'hF: pick_index = J_SHIFT;
            4'h8: pick_index = h[MODE_MEM_ORIGIN] ? J_IR : J_IM;
            default: pick_index = J_PRI;
         endcase
      end else begin
         unique case (m)
            4'h0: pick_index = dz ? J_PRI : J_OPC;
            4'h1, 4'h2: pick_index = dz ? J_ALT : J_OPC;
            4'h3: pick_index = dz ? J_ALT : J_MM;
            4'h4, 4'h5, 4'h6, 4'h7: pick_index = J_ALT;
            4'h8: pick_index = dz ? J_PRI : J_OPC;
            4'h9, 4'hA, 4'hB: pick_index = J_PRI;
            default: pick_index = dz ? J_MM : J_ALT;
         endcase
      end
   endfunction

   // upper half of the micro word encoded from the held instruction
   function automatic logic [15:0] encode_upper(input logic [15:0] h, input logic [7:0] dl);
      logic [3:0] m;
      m = mode_of(h);
      if (opc_of(h) == OPC_REGREF) begin
         unique case (m)
            4'h0, 4'h4, 4'h5, 4'hB: encode_upper = MC_NOP;
            4'h2, 4'h3: encode_upper = MC_PDSE_F_AB;
            4'h6, 4'h7: encode_upper = MC_Q_X_AB;
            4'h8: encode_upper = MC_INTERREG;
            4'hE: encode_upper = MC_DINT_X_AB;
            4'hF: encode_upper = MC_A_F;
            default: encode_upper = MC_PINC_P_AB;
         endcase
      end else if (dl == DELTA_ZERO) begin
         encode_upper = MC_PINC_P_AB;
      end else begin
         unique case (m)
            4'h0: encode_upper = MC_D_X_AB;
            4'h1, 4'h3: encode_upper = MC_DFF_X_AB;
            4'h2: encode_upper = MC_DQ_X_AB;
            4'h4, 4'h5, 4'h6, 4'h7: encode_upper = MC_D_X_AB;
            default: encode_upper = MC_PDSE_X_AB;
         endcase
      end
   endfunction

   function automatic logic is_enhanced(input logic [15:0] h, input logic [7:0] dl);
      logic [3:0] m;
      m = mode_of(h);
      is_enhanced = (opc_of(h) == OPC_REGREF) && (dl != DELTA_ZERO) &&
                    (m == 4'h0 || m == 4'h4 || m == 4'h5 || m == 4'h6 ||
                     m == 4'h7 || m == 4'hB);
   endfunction

   // micro address bit patterns of the fifteen transforms
   function automatic logic [7:0] xform_addr(input logic [3:0] j, input logic [15:0] h,
                                             input logic [7:0] dl, input logic [15:0] sl,
                                             input logic a, input logic c, input logic d);
      logic dz;
      dz = (dl == DELTA_ZERO);
      unique case (j)
         J_INT: xform_addr = {PFX_INT, a, 1'b0};
         J_IR2: xform_addr = {PFX_IR2, dl[4:3], 1'b0};
         J_FLD: xform_addr = {PFX_FLD, dl[2:0]};
         J_DEST: xform_addr = {PFX_DEST, dl[2:0]};
         J_MISC_ALT: xform_addr = {PFX_MISC_ALT, dl[4:0]};
         J_ENH: xform_addr = {PFX_ENH, dl[7:6], dz, 1'b0};
         J_SEL: xform_addr = sl[7:0];
         J_SKIP: xform_addr = {PFX_SKIP, dl[7:4], 1'b0};
         J_SHIFT: xform_addr = {PFX_SHIFT, dl[7:5]};
         J_IR: xform_addr = {PFX_IR, dl[3:0]};
         J_OPC: xform_addr = {PFX_OPC, opc_of(h), 1'b0};
         J_IM: xform_addr = {PFX_IM, dl[7:4]};
         J_PRI: xform_addr = {PFX_PRI, opc_of(h) == OPC_REGREF, mode_of(h), dz};
         J_ALT: xform_addr = {PFX_ALT, h[MODE_LO+2:MODE_LO]};
         J_MM: xform_addr = {PFX_MM, c, d};
         default: xform_addr = ADDR_UNUSED;
      endcase
   endfunction

   function automatic logic [31:0] read_mux(input state_t st, input logic [7:0] adr);
      read_mux = '0;
      if (reg_is(adr, REG_MACRO_DATA)) begin
         read_mux[15:0] = st.macro_data;
      end else if (reg_is(adr, REG_MICRO_LOW)) begin
         read_mux[15:0] = st.micro_low;
      end else if (reg_is(adr, REG_SELECTOR)) begin
         read_mux[15:0] = st.selector;
      end else if (reg_is(adr, REG_COND)) begin
         read_mux[1:0] = st.cond;
      end else if (reg_is(adr, REG_HOLD)) begin
         read_mux[23:0] = {st.delta, st.holder};
      end else if (reg_is(adr, REG_STATUS)) begin
         read_mux[16:0] = {st.enhanced, st.cond_d, st.cond_c, st.cond_b, st.cond_a,
                           st.index, st.addr};
      end else if (reg_is(adr, REG_MICRO_WORD)) begin
         read_mux = st.micro_word;
      end
   endfunction

   always_comb begin
      next_s = s;
      req_hit = wb_req_in.cyc & wb_req_in.stb;
      wr_go = req_hit & wb_req_in.we & s.ack;
      fetch_go = wr_go & reg_is(wb_req_in.adr, REG_CMD) & wb_req_in.sel[0] &
                 wb_req_in.dat[CMD_FETCH_BIT];
      micro_go = wr_go & reg_is(wb_req_in.adr, REG_CMD) & wb_req_in.sel[0] &
                 wb_req_in.dat[CMD_MICRO_BIT] & ~fetch_go;
      next_s.ack = req_hit & ~s.ack;
      next_s.rdata = (req_hit & ~s.ack & ~wb_req_in.we) ? read_mux(s, wb_req_in.adr) : '0;
      if (wr_go && reg_is(wb_req_in.adr, REG_MACRO_DATA)) begin
         next_s.macro_data = merge16(s.macro_data, wb_req_in.dat, wb_req_in.sel);
      end
      if (wr_go && reg_is(wb_req_in.adr, REG_MICRO_LOW)) begin
         next_s.micro_low = merge16(s.micro_low, wb_req_in.dat, wb_req_in.sel);
      end
      if (wr_go && reg_is(wb_req_in.adr, REG_SELECTOR)) begin
         next_s.selector = merge16(s.selector, wb_req_in.dat, wb_req_in.sel);
      end
      if (wr_go && reg_is(wb_req_in.adr, REG_COND) && wb_req_in.sel[0]) begin
         next_s.cond = wb_req_in.dat[1:0];
      end
      // decode on the values the holders take at this edge
      use_holder = fetch_go ? s.macro_data : s.holder;
      use_delta = fetch_go ? s.macro_data[7:0] : s.delta;
      use_index = fetch_go ? pick_index(use_holder, use_delta) : s.micro_low[3:0];
      use_a = (use_holder == IIN_CODE) | s.selector[SEL_BIT_NINE];
      use_b = (use_holder[MODE_HI -: 2] == MODE_DIRECT) | s.cond[COND_MLI_BIT];
      use_c = s.cond[COND_PROT_BIT];
      use_d = (use_delta == DELTA_ZERO) | use_b;
      next_s.strobe = fetch_go | micro_go;
      if (fetch_go || micro_go) begin
         next_s.holder = use_holder;
         next_s.delta = use_delta;
         next_s.index = use_index;
         next_s.addr = xform_addr(use_index, use_holder, use_delta, s.selector,
                                  use_a, use_c, use_d);
         next_s.cond_a = use_a;
         next_s.cond_b = use_b;
         next_s.cond_c = use_c;
         next_s.cond_d = use_d;
         next_s.enhanced = is_enhanced(use_holder, use_delta);
         next_s.micro_word = {fetch_go ? encode_upper(use_holder, use_delta) :
                              s.micro_word[31:16], s.micro_low};
      end
   end

   always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign wb_rsp_out = {s.ack, s.rdata};
   assign xform_out = {s.strobe, s.addr, s.micro_word};

   hold_load_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      fetch_go |=> (s.holder == $past(s.macro_data)) && (s.delta == $past(s.macro_data[7:0])))
      else $error("holders not loaded by fetch");

   low_half_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      fetch_go |=> s.micro_word[15:0] == $past(s.micro_low))
      else $error("lower micro word not from micro memory");

   micro_index_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      micro_go |=> s.strobe && (s.index == $past(s.micro_low[3:0])))
      else $error("index not taken from micro word bits");

   selector_byte_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (s.strobe && s.index == J_SEL) |-> s.addr == s.selector[7:0])
      else $error("selector byte not passed");

   shift_index_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (fetch_go && opc_of(s.macro_data) == OPC_REGREF && mode_of(s.macro_data) == 4'hF)
      |=> s.index == J_SHIFT && s.micro_word[31:16] == MC_A_F)
      else $error("shift code not decoded");

   cond_a_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      $rose(s.strobe) |-> s.cond_a == ((s.holder == IIN_CODE) | s.selector[SEL_BIT_NINE]))
      else $error("condition A wrong");

   zero_delta_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (fetch_go && opc_of(s.macro_data) != OPC_REGREF && s.macro_data[7:0] == DELTA_ZERO)
      |=> s.micro_word[31:16] == MC_PINC_P_AB)
      else $error("zero delta not incrementing P");

   rel_indirect_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (fetch_go && opc_of(s.macro_data) != OPC_REGREF && s.macro_data[MODE_HI -: 2] == 2'h3)
      |=> s.index == ((s.delta == DELTA_ZERO) ? J_MM : J_ALT))
      else $error("relative indirect dispatch wrong");

   enhanced_flag_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (s.strobe && s.enhanced) |-> (s.delta != DELTA_ZERO) && (opc_of(s.holder) == OPC_REGREF))
      else $error("enhanced flag with zero delta");

   bus_ack_a: assert property (
      @(posedge clk_sys_in) disable iff (!arst_n_in)
      (req_hit && !s.ack) |=> s.ack ##1 !s.ack)
      else $error("ack not one cycle after request");
endmodule
`default_nettype wire

/* File: core/macro_xform_pkg.sv */
// constants, register map and carrier types for the macro instruction transform decoder
package macro_xform_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_MACRO_DATA = 8'h04;
   localparam logic [7:0] REG_MICRO_LOW = 8'h08;
   localparam logic [7:0] REG_SELECTOR = 8'h0C;
   localparam logic [7:0] REG_COND = 8'h10;
   localparam logic [7:0] REG_HOLD = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_MICRO_WORD = 8'h1C;
   localparam logic [1:0] WORD_ALIGN = 2'h0;
   // command and condition bits
   localparam int CMD_FETCH_BIT = 0;
   localparam int CMD_MICRO_BIT = 1;
   localparam int COND_MLI_BIT = 0;
   localparam int COND_PROT_BIT = 1;
   // instruction fields (lsb numbering)
   localparam int OPC_HI = 15;
   localparam int OPC_LO = 12;
   localparam int MODE_HI = 11;
   localparam int MODE_LO = 8;
   localparam int MODE_MEM_ORIGIN = 3;
   localparam int SEL_BIT_NINE = 6;
   localparam logic [15:0] IIN_CODE = 16'h0500;
   localparam logic [7:0] DELTA_ZERO = 8'h00;
   localparam logic [3:0] OPC_REGREF = 4'h0;
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   // transform indices
   localparam logic [3:0] J_INT = 4'h0;
   localparam logic [3:0] J_IR2 = 4'h1;
   localparam logic [3:0] J_FLD = 4'h2;
   localparam logic [3:0] J_DEST = 4'h3;
   localparam logic [3:0] J_MISC_ALT = 4'h4;
   localparam logic [3:0] J_ENH = 4'h6;
   localparam logic [3:0] J_SEL = 4'h7;
   localparam logic [3:0] J_SKIP = 4'h8;
   localparam logic [3:0] J_SHIFT = 4'h9;
   localparam logic [3:0] J_IR = 4'hA;
   localparam logic [3:0] J_OPC = 4'hB;
   localparam logic [3:0] J_IM = 4'hC;
   localparam logic [3:0] J_PRI = 4'hD;
   localparam logic [3:0] J_ALT = 4'hE;
   localparam logic [3:0] J_MM = 4'hF;
   // fixed high bits of each address pattern except the selector byte one
   localparam logic [5:0] PFX_INT = 6'h01;
   localparam logic [4:0] PFX_IR2 = 5'h17;
   localparam logic [4:0] PFX_FLD = 5'h1B;
   localparam logic [4:0] PFX_DEST = 5'h07;
   localparam logic [2:0] PFX_MISC_ALT = 3'h7;
   localparam logic [3:0] PFX_ENH = 4'hA;
   localparam logic [2:0] PFX_SKIP = 3'h5;
   localparam logic [4:0] PFX_SHIFT = 5'h16;
   localparam logic [3:0] PFX_IR = 4'hC;
   localparam logic [2:0] PFX_OPC = 3'h4;
   localparam logic [3:0] PFX_IM = 4'hE;
   localparam logic [1:0] PFX_PRI = 2'h0;
   localparam logic [4:0] PFX_ALT = 5'h14;
   localparam logic [5:0] PFX_MM = 6'h2E;
   localparam logic [7:0] ADDR_UNUSED = 8'h00;
   // encoded upper micro commands
   localparam logic [15:0] MC_NOP = 16'h0000;
   localparam logic [15:0] MC_D_X_AB = 16'h1100;
   localparam logic [15:0] MC_DFF_X_AB = 16'h1200;
   localparam logic [15:0] MC_DQ_X_AB = 16'h1300;
   localparam logic [15:0] MC_PINC_P_AB = 16'h2100;
   localparam logic [15:0] MC_PDSE_X_AB = 16'h2200;
   localparam logic [15:0] MC_PDSE_F_AB = 16'h2300;
   localparam logic [15:0] MC_Q_X_AB = 16'h3100;
   localparam logic [15:0] MC_DINT_X_AB = 16'h3200;
   localparam logic [15:0] MC_A_F = 16'h4100;
   localparam logic [15:0] MC_INTERREG = 16'h5100;
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [7:0] adr;
      logic [31:0] dat;
   } wb_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } wb_rsp_t;
   typedef struct packed {
      logic strobe;
      logic [7:0] addr;
      logic [31:0] word;
   } xform_out_t;
endpackage
